// >>> include/lut_map_pkg.sv
// Shared constants, register map and carrier types of the pixel table mapper.
`default_nettype none
package lut_map_pkg;

  // ==========================================================================
  // Widths and sizes
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned BE_W = 4;
  localparam int unsigned PIX_W = 16;
  localparam int unsigned IDX_W = 11;
  localparam int unsigned COEF_W = 9;
  localparam int unsigned LANES = 3;
  localparam int unsigned TABLE_DEPTH = 2048;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned DEFAULT_SHIFT = 2;

  // ==========================================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 14'h0000;
  localparam logic [ADDR_W-1:0] SELECT_OFS = 14'h0004;
  localparam logic [ADDR_W-1:0] INDEX_OFS = 14'h0008;
  localparam logic [ADDR_W-1:0] VALUE_OFS = 14'h000c;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 14'h0010;
  localparam int unsigned BULK_BIT = 13;
  localparam int unsigned WORD_LSB = 2;

  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_FMT_LSB = 4;
  localparam int unsigned CTRL_COLOR_BIT = 8;
  localparam int unsigned STATUS_EN_BIT = 0;
  localparam int unsigned STATUS_STAGE_BIT = 1;
  localparam int unsigned STATUS_LEVEL_LSB = 8;
  localparam logic [IDX_W-1:0] TABLE_MAX = 11'h7ff;
  localparam logic [IDX_W-1:0] INDEX_RESET = 11'h000;
  localparam logic [COEF_W-1:0] SELECT_ONLY = 9'h000;

  // ==========================================================================
  // Types
  typedef logic [DATA_W-1:0] word_t;

  typedef enum logic [1:0] {
    FMT_8 = 2'b00,
    FMT_12 = 2'b01,
    FMT_16 = 2'b10,
    FMT_16_ALT = 2'b11
  } out_format_t;

  typedef enum logic {
    COLOR_SINGLE = 1'b0,
    COLOR_THREE = 1'b1
  } color_mode_t;

  typedef struct packed {
    logic [LANES-1:0][PIX_W-1:0] lane;
  } pixel_beat_t;

  typedef struct packed {
    logic enable;
    out_format_t fmt;
    color_mode_t color;
    logic [IDX_W-1:0] index;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{enable: 1'b0, fmt: FMT_8, color: COLOR_SINGLE,
                                   index: INDEX_RESET};

endpackage : lut_map_pkg
`default_nettype wire

// >>> rtl/pixel_lookup_table_mapper.sv
// Pixel table mapper: register slave, lookup stage, formatter and output FIFO.
//
// How it works
// - 11-bit index gives a 9-bit mapped value.
// - Pixels above 2047 saturate to entry 2047.
// - 8-bit output drops the lowest mapped bit.
// - 12-bit output: mapped value, three zero bits.
// - 16-bit output: mapped value, seven zero bits.
// - Mapping works with every output format.
// - Reset table holds linear entry index/4.
// - One table only; selector offers one choice.
// - Coefficient writes land at once, no shadow.
// - Index register picks entry for value access.
// - Value read returns, write replaces indexed entry.
// - Bulk window reaches every entry without index.
// - Three colour channels share the same table.
// - Mono and Bayer streams use one channel.
// - Table is volatile and reverts to default.
// - Table applies only while enable is set.
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// ============================================================================
// Output FIFO
module pixel_fifo #(
  parameter int unsigned WIDTH = 48,
  parameter int unsigned DEPTH = 16
) (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = $clog2(DEPTH+1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH-1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [CNT_W-1:0] count;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = ce && (q.count != CNT_FULL);
  assign out_valid = (q.count != '0);
  assign out_data = q.mem[q.rptr];
  assign level = q.count;
  assign push = in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  // Next state of storage, pointers and count.
  // Pointers wrap at the last slot, so any depth works.
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wptr] = in_data;
      d.wptr = (q.wptr == PTR_LAST) ? '0 : q.wptr + PTR_W'(1);
    end
    if (pop) begin
      d.rptr = (q.rptr == PTR_LAST) ? '0 : q.rptr + PTR_W'(1);
    end
    if (push && !pop) begin
      d.count = q.count + CNT_W'(1);
    end else if (pop && !push) begin
      d.count = q.count - CNT_W'(1);
    end
  end

  // State register; the enable freezes everything.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

endmodule : pixel_fifo

// ============================================================================
// Top level
module pixel_lookup_table_mapper #(
  parameter int unsigned TABLE_DEPTH = lut_map_pkg::TABLE_DEPTH,
  parameter int unsigned FIFO_DEPTH = lut_map_pkg::FIFO_DEPTH
) (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Avalon-MM register slave
  input wire logic [lut_map_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [lut_map_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [lut_map_pkg::BE_W-1:0] avs_byteenable,
  output logic [lut_map_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Pixel stream from the sensor path
  input wire logic in_valid,
  output logic in_ready,
  input wire lut_map_pkg::pixel_beat_t in_beat,
  // Pixel stream to the output formatter
  output logic out_valid,
  input wire logic out_ready,
  output lut_map_pkg::pixel_beat_t out_beat
);

  localparam int unsigned LVL_W = $clog2(FIFO_DEPTH+1);
  localparam int unsigned BEAT_W = $bits(lut_map_pkg::pixel_beat_t);

  typedef logic [TABLE_DEPTH-1:0][lut_map_pkg::COEF_W-1:0] table_t;

  typedef struct packed {
    table_t coef;
    lut_map_pkg::ctrl_t ctrl;
    logic stage_valid;
    lut_map_pkg::pixel_beat_t stage_beat;
    logic rd_ack;
    lut_map_pkg::word_t rdata;
  } state_t;

  // Linear default: each entry is its own index divided by four.
  function automatic state_t reset_state();
    state_t s;
    s = '0;
    for (int i = 0; i < TABLE_DEPTH; i++) begin
      s.coef[i] = lut_map_pkg::COEF_W'(i >> lut_map_pkg::DEFAULT_SHIFT);
    end
    s.ctrl = lut_map_pkg::CTRL_RESET;
    return s;
  endfunction : reset_state

  // Byte-lane merge of a write into the old word.
  function automatic lut_map_pkg::word_t merge(input lut_map_pkg::word_t old,
                                               input lut_map_pkg::word_t wd,
                                               input logic [lut_map_pkg::BE_W-1:0] be);
    lut_map_pkg::word_t r;
    r = old;
    for (int b = 0; b < lut_map_pkg::BE_W; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Control register as seen by software.
  function automatic lut_map_pkg::word_t ctrl_word(input lut_map_pkg::ctrl_t c);
    lut_map_pkg::word_t w;
    w = '0;
    w[lut_map_pkg::CTRL_EN_BIT] = c.enable;
    w[lut_map_pkg::CTRL_FMT_LSB +: 2] = c.fmt;
    w[lut_map_pkg::CTRL_COLOR_BIT] = c.color;
    return w;
  endfunction : ctrl_word

  state_t q;
  state_t d;
  // Shared beat net; every lane drives only its own slice of it.
  wire lut_map_pkg::pixel_beat_t mapped_beat;
  logic fifo_in_ready;
  logic [BEAT_W-1:0] fifo_out;
  logic [LVL_W-1:0] fifo_level;
  logic is_bulk;
  logic [lut_map_pkg::IDX_W-1:0] bulk_idx;
  logic [lut_map_pkg::COEF_W-1:0] indexed_coef;

  // ==========================================================================
  // Per-channel lookup and output formatting
  genvar g;
  generate
    for (g = 0; g < lut_map_pkg::LANES; g++) begin : lane_map
      logic [lut_map_pkg::IDX_W-1:0] sat_idx;
      logic [lut_map_pkg::COEF_W-1:0] coef;
      logic [lut_map_pkg::PIX_W-1:0] shaped;
      logic [lut_map_pkg::PIX_W-1:0] chosen;

      // Saturation keeps out-of-range pixels on the last entry.
      // saturate before lookup.
      assign sat_idx = (in_beat.lane[g] > lut_map_pkg::PIX_W'(lut_map_pkg::TABLE_MAX)) ?
                       lut_map_pkg::TABLE_MAX : in_beat.lane[g][lut_map_pkg::IDX_W-1:0];
      // index the table; same table on every lane.
      assign coef = q.coef[sat_idx];

      // Place the mapped value according to the output width.
      always_comb begin
        case (q.ctrl.fmt)
          lut_map_pkg::FMT_8: begin
            shaped = lut_map_pkg::PIX_W'(coef[lut_map_pkg::COEF_W-1:1]);
          end
          lut_map_pkg::FMT_12: begin
            shaped = lut_map_pkg::PIX_W'({coef, 3'h0});
          end
          lut_map_pkg::FMT_16: begin
            shaped = {coef, 7'h00};
          end
          default: begin
            shaped = {coef, 7'h00};
          end
        endcase
      end

      // Select mapped or raw value, and blank unused lanes in single mode while enabled.
      always_comb begin
        // bypass when disabled; map only when enabled.
        if (!q.ctrl.enable) begin
          chosen = in_beat.lane[g];
        end else if ((q.ctrl.color == lut_map_pkg::COLOR_SINGLE) && (g != 0)) begin
          chosen = '0;
        end else begin
          chosen = shaped;
        end
      end

      // Each lane drives its own slice, so no two processes share a variable.
      assign mapped_beat.lane[g] = chosen;
    end
  endgenerate

  // ==========================================================================
  // Bus decode helpers
  // The top address bit opens the bulk window; the word address picks its entry.
  assign is_bulk = avs_address[lut_map_pkg::BULK_BIT];
  assign bulk_idx = avs_address[lut_map_pkg::WORD_LSB +: lut_map_pkg::IDX_W];
  assign indexed_coef = q.coef[q.ctrl.index];

  // Reads wait one cycle for registered data; writes are taken at once.
  assign avs_waitrequest = !ce || (avs_read && !q.rd_ack);
  assign avs_readdata = q.rdata;
  assign in_ready = ce && (!q.stage_valid || fifo_in_ready);

  // ==========================================================================
  // Next-state logic for registers, table and stage
  always_comb begin
    lut_map_pkg::word_t m;
    m = '0;
    d = q;

    // Read: capture data, then release on the following cycle.
    // Holding the acknowledge one cycle keeps read data coming from a flop.
    if (avs_read && !q.rd_ack) begin
      d.rd_ack = 1'b1;
      if (is_bulk) begin
        d.rdata = lut_map_pkg::word_t'(q.coef[bulk_idx]);
      end else begin
        case (avs_address)
          lut_map_pkg::CTRL_OFS: d.rdata = ctrl_word(q.ctrl);
          lut_map_pkg::SELECT_OFS: d.rdata = lut_map_pkg::word_t'(lut_map_pkg::SELECT_ONLY);
          lut_map_pkg::INDEX_OFS: d.rdata = lut_map_pkg::word_t'(q.ctrl.index);
          lut_map_pkg::VALUE_OFS: d.rdata = lut_map_pkg::word_t'(indexed_coef);
          lut_map_pkg::STATUS_OFS: begin
            d.rdata = '0;
            d.rdata[lut_map_pkg::STATUS_EN_BIT] = q.ctrl.enable;
            d.rdata[lut_map_pkg::STATUS_STAGE_BIT] = q.stage_valid;
            d.rdata[lut_map_pkg::STATUS_LEVEL_LSB +: LVL_W] = fifo_level;
          end
          default: d.rdata = '0;
        endcase
      end
    end else if (avs_read) begin
      d.rd_ack = 1'b0;
    end

    // Write: applied in the cycle it is presented.
    // Byte enables merge each write into the current register value.
    if (avs_write) begin
      if (is_bulk) begin
        m = merge(lut_map_pkg::word_t'(q.coef[bulk_idx]), avs_writedata, avs_byteenable);
        d.coef[bulk_idx] = m[lut_map_pkg::COEF_W-1:0];
      end else begin
        case (avs_address)
          lut_map_pkg::CTRL_OFS: begin
            m = merge(ctrl_word(q.ctrl), avs_writedata, avs_byteenable);
            d.ctrl.enable = m[lut_map_pkg::CTRL_EN_BIT];
            d.ctrl.fmt = lut_map_pkg::out_format_t'(m[lut_map_pkg::CTRL_FMT_LSB +: 2]);
            d.ctrl.color = lut_map_pkg::color_mode_t'(m[lut_map_pkg::CTRL_COLOR_BIT]);
          end
          lut_map_pkg::SELECT_OFS: begin
            // only one selectable table, nothing to store.
            d.ctrl = q.ctrl;
          end
          lut_map_pkg::INDEX_OFS: begin
            m = merge(lut_map_pkg::word_t'(q.ctrl.index), avs_writedata, avs_byteenable);
            if (m[lut_map_pkg::DATA_W-1:lut_map_pkg::IDX_W] == '0) begin
              d.ctrl.index = m[lut_map_pkg::IDX_W-1:0];
            end
          end
          lut_map_pkg::VALUE_OFS: begin
            m = merge(lut_map_pkg::word_t'(indexed_coef), avs_writedata, avs_byteenable);
            // replace indexed entry; no shadow copy.
            d.coef[q.ctrl.index] = m[lut_map_pkg::COEF_W-1:0];
          end
          default: begin
            d.ctrl = q.ctrl;
          end
        endcase
      end
    end

    // Lookup stage, stalled by the FIFO.
    // The table is read in the accepting cycle, so a write in that cycle is not seen.
    if (in_valid && in_ready) begin
      d.stage_valid = 1'b1;
      d.stage_beat = mapped_beat;
    end else if (fifo_in_ready) begin
      d.stage_valid = 1'b0;
    end
  end

  // The linear table is rebuilt on every reset, so user entries never survive it.
  // reset reloads the linear table.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= reset_state();
    end else if (ce) begin
      q <= d;
    end
  end

  // ==========================================================================
  // Output buffer
  pixel_fifo #(
    .WIDTH(BEAT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .in_valid(q.stage_valid),
    .in_ready(fifo_in_ready),
    .in_data(q.stage_beat),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  // Beat type restored from the FIFO word.
  assign out_beat = lut_map_pkg::pixel_beat_t'(fifo_out);

endmodule : pixel_lookup_table_mapper

`default_nettype wire

// >>> verification/pixel_sink_model.sv
// Downstream consumer model that paces the mapper's output stream.
`timescale 1ns/100ps
`default_nettype none
module pixel_sink_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pacing from the bench
  input wire logic stall,
  input wire logic slow,
  // Consumer handshake
  output logic out_ready
);
  logic tick_q;

  // Ready drops while stalled, and on every other cycle when slow.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_q <= 1'b0;
      out_ready <= 1'b0;
    end else begin
      tick_q <= ~tick_q;
      out_ready <= !stall && (!slow || tick_q);
    end
  end
endmodule : pixel_sink_model
`default_nettype wire

// >>> verification/pixel_map_sva.sv
// Port checker for the pixel table mapper, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module pixel_map_sva (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Register bus
  input wire logic [lut_map_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [lut_map_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pixel streams
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire lut_map_pkg::pixel_beat_t out_beat
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_write_now;
    avs_write && ce |-> !avs_waitrequest;
  endproperty
  a_write_now: assert property (p_write_now) else $error("write stalled");

  property p_read_wait;
    $rose(avs_read) && ce |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait wrong");

  property p_read_stands;
    !avs_read |=> $stable(avs_readdata);
  endproperty
  a_read_stands: assert property (p_read_stands) else $error("read data moved");

  property p_select_zero;
    $rose(avs_read) && ce && avs_address == lut_map_pkg::SELECT_OFS |=> avs_readdata == '0;
  endproperty
  a_select_zero: assert property (p_select_zero) else $error("selector not zero");

  property p_unmapped_zero;
    $rose(avs_read) && ce && avs_address == 14'h1000 |=> avs_readdata == '0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped not zero");

  property p_frozen;
    !ce |-> avs_waitrequest && !in_ready;
  endproperty
  a_frozen: assert property (p_frozen) else $error("not frozen");

  property p_out_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_beat);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output beat moved");

  property p_latency;
    in_valid && in_ready && !out_valid |-> ##[1:2] out_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("beat late");

  property p_full_only;
    ce && !in_ready |-> out_valid;
  endproperty
  a_full_only: assert property (p_full_only) else $error("refused while empty");
endmodule : pixel_map_sva

bind pixel_lookup_table_mapper pixel_map_sva i_sva (.sys_clk, .rst, .ce, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .in_valid, .in_ready,
  .out_valid, .out_ready, .out_beat);
`default_nettype wire

// >>> verification/pixel_lookup_table_mapper_bench.sv
// Self-checking bench for the pixel table mapper.
`timescale 1ns/100ps
`default_nettype none
module pixel_lookup_table_mapper_bench;
  // ==========================================================================
  // Signals and instances
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic in_valid = 1'b0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic avs_waitrequest, in_ready, out_valid, out_ready;
  logic [lut_map_pkg::ADDR_W-1:0] avs_address = '0;
  lut_map_pkg::word_t avs_writedata = '0;
  lut_map_pkg::word_t avs_readdata, rd;
  lut_map_pkg::pixel_beat_t in_beat = '0;
  lut_map_pkg::pixel_beat_t out_beat;
  int mismatches = 0;
  int compares = 0;

  // Free-running clock of 50 ns.
  always #25 sys_clk = ~sys_clk;

  pixel_lookup_table_mapper i_dut (.sys_clk, .rst, .ce, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .in_valid, .in_ready, .in_beat, .out_valid, .out_ready, .out_beat);
  pixel_sink_model i_sink (.sys_clk, .rst, .stall, .slow, .out_ready);

  // ==========================================================================
  // Shared tasks
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic hang();
    mismatches++;
    $display("MISMATCH %0t wait ran out", $time);
    print_verdict();
  endtask : hang

  task automatic check_word(input lut_map_pkg::word_t got, input lut_map_pkg::word_t exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_pix(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t pixel %h expected %h", $time, got, exp);
    end
  endtask : check_pix

  // One bus cycle, held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [13:0] a, input lut_map_pkg::word_t d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) hang();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic rchk(input logic [13:0] a, input lut_map_pkg::word_t exp);
    bus(1'b0, a, '0);
    check_word(rd, exp);
  endtask : rchk

  // One beat in, one beat out, every lane compared.
  task automatic pix(input logic [2:0][15:0] p, input logic [2:0][15:0] e);
    int i;
    in_beat.lane <= p;
    in_valid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (in_ready === 1'b1) break;
    end
    if (i == 50) hang();
    in_valid <= 1'b0;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (out_valid === 1'b1 && out_ready === 1'b1) break;
    end
    if (i == 50) hang();
    for (i = 0; i < 3; i++) check_pix(out_beat.lane[i], e[i]);
  endtask : pix

  // Expected output word of a coefficient in a given format.
  function automatic logic [15:0] fmt(input logic [8:0] c, input logic [1:0] f);
    case (f)
      2'h0: return {8'h00, c[8:1]};
      2'h1: return {4'h0, c, 3'h0};
      default: return {c, 7'h00};
    endcase
  endfunction : fmt

  // ==========================================================================
  // Scenarios
  task automatic t_coef();
    rchk(lut_map_pkg::VALUE_OFS, 32'h0);
    bus(1'b1, lut_map_pkg::CTRL_OFS, 32'h0);
    bus(1'b1, lut_map_pkg::INDEX_OFS, 32'h5);
    bus(1'b1, lut_map_pkg::VALUE_OFS, 32'h1ab);
    bus(1'b1, lut_map_pkg::INDEX_OFS, 32'h800);
    rchk(lut_map_pkg::INDEX_OFS, 32'h5);
    rchk(lut_map_pkg::VALUE_OFS, 32'h1ab);
    bus(1'b1, 14'h201c, 32'h0aa);
    rchk(14'h3ffc, 32'h1ff);
    bus(1'b1, lut_map_pkg::INDEX_OFS, 32'h7);
    rchk(lut_map_pkg::VALUE_OFS, 32'h0aa);
    bus(1'b1, lut_map_pkg::CTRL_OFS, 32'h21);
    pix({16'h0, 16'h0, 16'h0005}, {16'h0, 16'h0, fmt(9'h1ab, 2'h2)});
    bus(1'b1, lut_map_pkg::INDEX_OFS, 32'h5);
    bus(1'b1, lut_map_pkg::VALUE_OFS, 32'h033);
    pix({16'h0, 16'h0, 16'h0005}, {16'h0, 16'h0, fmt(9'h033, 2'h2)});
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(1'b1, lut_map_pkg::INDEX_OFS, 32'h5);
    rchk(lut_map_pkg::VALUE_OFS, 32'h1);
  endtask : t_coef

  task automatic t_formats();
    logic [2:0][15:0] p;
    logic [2:0][15:0] e;
    p = {16'h0bb8, 16'h07ff, 16'h0064};
    for (int f = 0; f < 4; f++) begin
      bus(1'b1, lut_map_pkg::CTRL_OFS, lut_map_pkg::word_t'(32'h101 | (f << 4)));
      for (int i = 0; i < 3; i++) e[i] = fmt((i == 0) ? 9'h019 : 9'h1ff, f[1:0]);
      pix(p, e);
    end
    bus(1'b1, lut_map_pkg::CTRL_OFS, 32'h11);
    pix(p, {16'h0, 16'h0, fmt(9'h019, 2'h1)});
  endtask : t_formats

  task automatic t_bypass();
    bus(1'b1, lut_map_pkg::CTRL_OFS, 32'h120);
    pix({16'h0bb8, 16'h07ff, 16'h0064}, {16'h0bb8, 16'h07ff, 16'h0064});
    ce <= 1'b0;
    repeat (4) @(posedge sys_clk);
    ce <= 1'b1;
    @(posedge sys_clk);
  endtask : t_bypass

  task automatic t_fill();
    int n;
    n = 0;
    stall <= 1'b1;
    bus(1'b1, lut_map_pkg::CTRL_OFS, 32'h0);
    in_valid <= 1'b1;
    repeat (30) begin
      @(posedge sys_clk);
      if (in_ready === 1'b1) n++;
    end
    in_valid <= 1'b0;
    check_word(n, lut_map_pkg::FIFO_DEPTH + 1);
    rchk(lut_map_pkg::STATUS_OFS, 32'h1002);
    stall <= 1'b0;
    slow <= 1'b1;
    n = 0;
    repeat (60) begin
      @(posedge sys_clk);
      if (out_valid === 1'b1 && out_ready === 1'b1) n++;
    end
    slow <= 1'b0;
    check_word(n, lut_map_pkg::FIFO_DEPTH + 1);
  endtask : t_fill

  task automatic t_regs();
    rchk(lut_map_pkg::SELECT_OFS, 32'h0);
    bus(1'b1, lut_map_pkg::SELECT_OFS, 32'h5);
    rchk(lut_map_pkg::SELECT_OFS, 32'h0);
    rchk(14'h1000, 32'h0);
  endtask : t_regs

  // Main sequence: reset, scenarios, verdict.
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_coef();
    t_formats();
    t_bypass();
    t_fill();
    t_regs();
    print_verdict();
  end
endmodule : pixel_lookup_table_mapper_bench
`default_nettype wire
